// >>> design/apso_top.sv
// absolute position serial output: revolution message, pulse burst, quad
// assumes sensor_on_pin is asynchronous; quadrature inputs share ref_clk
`timescale 1ns/100ps
`default_nettype none
module apso_top
#(
   parameter int SENSOR_CYC = apso_pkg::SENSOR_DELAY_CYC,
   parameter int RETURN_CYC = apso_pkg::RETURN_DELAY_CYC,
   parameter int BAUD_CYC = apso_pkg::BIT_CYC
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sensor_on_pin,
   input wire logic signed [35:0] abs_position,
   input wire logic inc_a,
   input wire logic inc_b,
   input wire logic index_in,
   output logic quad_a_out,
   output logic quad_b_out,
   output logic index_pulse_out,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   apso_pkg::apso_state_type state_ff, nxt_state;
   apso_pkg::apso_ctrl_type ctrl_ff;
   apso_pkg::apso_quad_type quad_ff, nxt_quad;
   logic [2:0] sync_ff;
   logic sensor_lvl_ff;
   logic sensor_rise;
   logic [31:0] wait_cnt_ff;
   logic [31:0] hold_cnt_ff;
   logic [5:0] prep_step_ff;
   logic prep_done_ff;
   logic pos_neg_ff;
   logic [35:0] quo_ff;
   logic [13:0] rem_ff;
   logic [13:0] trial;
   logic [35:0] quot_signed;
   logic signed [15:0] revs_ff;
   logic [19:0] remain_ff;
   logic [15:0] dig_work_ff;
   logic [2:0] place_ff;
   logic [3:0] dig_cnt_ff;
   logic [3:0] digit_ff [apso_pkg::DIGITS];
   logic [15:0] place_weight;
   logic [31:0] baud_cnt_ff;
   logic [3:0] bit_idx_ff;
   logic [2:0] char_idx_ff;
   logic [9:0] frame_ff;
   logic [6:0] cur_char;
   logic tx_line;
   logic [20:0] pulse_left_ff;
   logic [7:0] quarter_cnt_ff;
   logic [1:0] phase_ff;
   logic burst_a;
   logic burst_b;
   logic aw_held_ff;
   logic w_held_ff;
   logic [3:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;

   // sensor-on pin: three stages, change accepted when last two agree
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         sync_ff <= 3'h0;
      else
         sync_ff <= {sync_ff[1:0], sensor_on_pin};
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         sensor_lvl_ff <= 1'b0;
      else if (sync_ff[1] == sync_ff[2])
         sensor_lvl_ff <= sync_ff[2];
   end

   assign sensor_rise = (sync_ff[1] == sync_ff[2]) && sync_ff[2] &&
                        !sensor_lvl_ff;

   // sequence control
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         apso_pkg::ST_NORMAL:
            if (sensor_rise)
               nxt_state = apso_pkg::ST_WAIT;
         apso_pkg::ST_WAIT:
            if (wait_cnt_ff == 32'h0 && prep_done_ff)
               nxt_state = apso_pkg::ST_SERIAL;
         apso_pkg::ST_SERIAL:
            if (char_idx_ff == 3'h7 && bit_idx_ff == 4'h9 &&
                baud_cnt_ff == 32'h0)
               nxt_state = apso_pkg::ST_PULSES;
         apso_pkg::ST_PULSES:
            if (pulse_left_ff == 21'h0)
               nxt_state = apso_pkg::ST_HOLD;
         apso_pkg::ST_HOLD:
            if (hold_cnt_ff == 32'h0)
               nxt_state = apso_pkg::ST_NORMAL;
         default:
            nxt_state = apso_pkg::ST_NORMAL;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         state_ff <= apso_pkg::ST_NORMAL;
      else
         state_ff <= nxt_state;
   end

   // 100 ms wait, and 400 ms from the last character running under the burst
   always_ff @(posedge ref_clk)
   begin
      if (srst || state_ff != apso_pkg::ST_WAIT)
         wait_cnt_ff <= 32'(SENSOR_CYC - 1);
      else if (wait_cnt_ff != 32'h0)
         wait_cnt_ff <= wait_cnt_ff - 32'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || state_ff == apso_pkg::ST_SERIAL ||
          state_ff == apso_pkg::ST_NORMAL)
         hold_cnt_ff <= 32'(RETURN_CYC - 1);
      else if (hold_cnt_ff != 32'h0)
         hold_cnt_ff <= hold_cnt_ff - 32'h1;
   end

   // position over resolution: restoring divider, then decimal digits
   assign trial = {rem_ff[12:0], quo_ff[35]};
   assign quot_signed = pos_neg_ff ? 36'(-quo_ff) : quo_ff;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         prep_step_ff <= 6'h0;
         prep_done_ff <= 1'b0;
         pos_neg_ff <= 1'b0;
         quo_ff <= 36'h0;
         rem_ff <= 14'h0;
      end
      else if (state_ff == apso_pkg::ST_NORMAL && sensor_rise)
      begin
         prep_step_ff <= 6'h0;
         prep_done_ff <= 1'b0;
         pos_neg_ff <= abs_position[35];
         quo_ff <= abs_position[35] ? 36'(-abs_position) : abs_position;
         rem_ff <= 14'h0;
      end
      else if (prep_step_ff < 6'(apso_pkg::DIV_STEPS))
      begin
         prep_step_ff <= prep_step_ff + 6'h1;
         if (trial >= {1'b0, ctrl_ff.res})
         begin
            rem_ff <= trial - {1'b0, ctrl_ff.res};
            quo_ff <= {quo_ff[34:0], 1'b1};
         end
         else
         begin
            rem_ff <= trial;
            quo_ff <= {quo_ff[34:0], 1'b0};
         end
      end
      else if (prep_step_ff == 6'(apso_pkg::DIV_STEPS))
         prep_step_ff <= prep_step_ff + 6'h1;
      else if (place_ff == 3'(apso_pkg::DIGITS))
         prep_done_ff <= 1'b1;
   end

   // one unit of the count is 2^20 pulses; 16 bits wrap at the ends
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         revs_ff <= 16'h0;
         remain_ff <= 20'h0;
      end
      else if (prep_step_ff == 6'(apso_pkg::DIV_STEPS))
      begin
         revs_ff <= quot_signed[35:20];
         remain_ff <= quot_signed[19:0];
      end
   end

   always_comb
   begin
      case (place_ff)
         3'h0: place_weight = 16'h2710;
         3'h1: place_weight = 16'h03E8;
         3'h2: place_weight = 16'h0064;
         3'h3: place_weight = 16'h000A;
         default: place_weight = 16'h0001;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || prep_step_ff <= 6'(apso_pkg::DIV_STEPS))
      begin
         place_ff <= 3'h0;
         dig_cnt_ff <= 4'h0;
         // quotient is final at the capture step, revs_ff is not yet
         dig_work_ff <= quot_signed[35] ? 16'(-quot_signed[35:20]) :
                        quot_signed[35:20];
      end
      else if (place_ff < 3'(apso_pkg::DIGITS))
      begin
         if (dig_work_ff >= place_weight)
         begin
            dig_work_ff <= dig_work_ff - place_weight;
            dig_cnt_ff <= dig_cnt_ff + 4'h1;
         end
         else
         begin
            place_ff <= place_ff + 3'h1;
            dig_cnt_ff <= 4'h0;
         end
      end
   end

   for (genvar i = 0; i < apso_pkg::DIGITS; i++)
   begin : g_digit
      always_ff @(posedge ref_clk)
      begin
         if (srst)
            digit_ff[i] <= 4'h0;
         else if (place_ff == 3'(i) && dig_work_ff < place_weight &&
                  prep_step_ff > 6'(apso_pkg::DIV_STEPS))
            digit_ff[i] <= dig_cnt_ff;
      end
   end

   // character of the message; zero goes out as plus
   always_comb
   begin
      case (char_idx_ff)
         3'h0: cur_char = apso_pkg::CHAR_LEAD;
         3'h1: cur_char = revs_ff[15] ? apso_pkg::CHAR_MINUS :
                          apso_pkg::CHAR_PLUS;
         3'h7: cur_char = apso_pkg::CHAR_CR;
         default: cur_char = apso_pkg::CHAR_ZERO |
                             {3'h0, digit_ff[char_idx_ff - 3'h2]};
      endcase
   end

   // async frame: start, 7 data lsb first, even parity, stop
   always_ff @(posedge ref_clk)
   begin
      if (srst || state_ff != apso_pkg::ST_SERIAL)
      begin
         baud_cnt_ff <= 32'(BAUD_CYC - 1);
         bit_idx_ff <= 4'h0;
         char_idx_ff <= 3'h0;
         frame_ff <= {1'b1, ^cur_char, cur_char, 1'b0};
      end
      else
      begin
         // reload during the start bit, after char_idx_ff has moved on
         if (bit_idx_ff == 4'h0)
            frame_ff <= {1'b1, ^cur_char, cur_char, 1'b0};
         if (baud_cnt_ff != 32'h0)
            baud_cnt_ff <= baud_cnt_ff - 32'h1;
         else
         begin
            baud_cnt_ff <= 32'(BAUD_CYC - 1);
            if (bit_idx_ff == 4'(apso_pkg::FRAME_BITS - 1))
            begin
               bit_idx_ff <= 4'h0;
               char_idx_ff <= char_idx_ff + 3'h1;
            end
            else
               bit_idx_ff <= bit_idx_ff + 4'h1;
         end
      end
   end

   assign tx_line = frame_ff[bit_idx_ff];

   // burst of quadrature pulses, a leading when dir is 0 and b leading when dir is 1, one pulse every 1.48 us
   always_ff @(posedge ref_clk)
   begin
      if (srst || state_ff != apso_pkg::ST_PULSES)
      begin
         pulse_left_ff <= {1'b0, remain_ff};
         quarter_cnt_ff <= 8'(apso_pkg::QUARTER_CYC - 1);
         phase_ff <= 2'h0;
      end
      else if (quarter_cnt_ff != 8'h0)
         quarter_cnt_ff <= quarter_cnt_ff - 8'h1;
      else
      begin
         quarter_cnt_ff <= 8'(apso_pkg::QUARTER_CYC - 1);
         phase_ff <= phase_ff + 2'h1;
         if (phase_ff == 2'h3)
            pulse_left_ff <= pulse_left_ff - 21'h1;
      end
   end

   assign burst_a = (phase_ff == 2'h1) || (phase_ff == 2'h2);
   assign burst_b = phase_ff[1];

   // output select per phase of the sequence
   always_comb
   begin
      nxt_quad.c = index_in;
      case (state_ff)
         apso_pkg::ST_WAIT:
         begin
            nxt_quad.a = 1'b1;
            nxt_quad.b = ctrl_ff.dir;
         end
         apso_pkg::ST_SERIAL:
         begin
            nxt_quad.a = tx_line;
            nxt_quad.b = ctrl_ff.dir;
         end
         apso_pkg::ST_PULSES:
         begin
            nxt_quad.a = burst_a;
            nxt_quad.b = burst_b ^ ctrl_ff.dir;
         end
         apso_pkg::ST_HOLD:
         begin
            nxt_quad.a = 1'b0;
            nxt_quad.b = ctrl_ff.dir;
         end
         default:
         begin
            nxt_quad.a = inc_a;
            nxt_quad.b = inc_b;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         quad_ff <= '{a: 1'b0, b: 1'b0, c: 1'b0};
      else
         quad_ff <= nxt_quad;
   end

   assign quad_a_out = quad_ff.a;
   assign quad_b_out = quad_ff.b;
   assign index_pulse_out = quad_ff.c;

   // axi4-lite write side
   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready = !w_held_ff;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff <= 32'h0;
         w_strb_ff <= 4'h0;
      end
      else if (aw_held_ff && w_held_ff && !s_axi_bvalid)
      begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held_ff)
         begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_ff)
         begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
      end
   end

   // resolution outside 1..4096 is ignored
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         ctrl_ff <= '{dir: apso_pkg::DIR_RESET, res: apso_pkg::RES_RESET};
      else if (aw_held_ff && w_held_ff && !s_axi_bvalid &&
               aw_addr_ff == apso_pkg::REG_CTRL_OFS)
      begin
         if (w_strb_ff[2])
            ctrl_ff.dir <= w_data_ff[apso_pkg::CTRL_DIR_BIT];
         if (w_strb_ff[1:0] == 2'h3 &&
             w_data_ff[12:0] >= apso_pkg::RES_MIN &&
             w_data_ff[12:0] <= apso_pkg::RES_MAX &&
             w_data_ff[15:13] == 3'h0)
            ctrl_ff.res <= w_data_ff[12:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= apso_pkg::RESP_OKAY;
      end
      else if (aw_held_ff && w_held_ff && !s_axi_bvalid)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr_ff == apso_pkg::REG_CTRL_OFS) ?
                        apso_pkg::RESP_OKAY : apso_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // axi4-lite read side
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= apso_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= apso_pkg::RESP_OKAY;
         if (s_axi_araddr == apso_pkg::REG_CTRL_OFS)
            s_axi_rdata <= {15'h0, ctrl_ff.dir, 3'h0, ctrl_ff.res};
         else if (s_axi_araddr == apso_pkg::REG_STATUS_OFS)
            s_axi_rdata <= {27'h0, state_ff == apso_pkg::ST_HOLD,
                            state_ff == apso_pkg::ST_PULSES,
                            state_ff == apso_pkg::ST_SERIAL,
                            state_ff == apso_pkg::ST_WAIT, sensor_lvl_ff};
         else if (s_axi_araddr == apso_pkg::REG_REVS_OFS)
            s_axi_rdata <= {{16{revs_ff[15]}}, revs_ff};
         else if (s_axi_araddr == apso_pkg::REG_REMAIN_OFS)
            s_axi_rdata <= {12'h0, remain_ff};
         else
         begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= apso_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // checks
   sequence s_frame_start;
      state_ff == apso_pkg::ST_SERIAL && baud_cnt_ff == 32'(BAUD_CYC - 1) &&
      bit_idx_ff == 4'h0;
   endsequence

   property p_start_bit;
      @(posedge ref_clk) disable iff (srst)
      s_frame_start |=> !quad_a_out;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("no start bit");

   property p_wait_exit;
      @(posedge ref_clk) disable iff (srst)
      (state_ff == apso_pkg::ST_WAIT && nxt_state == apso_pkg::ST_SERIAL)
      |-> wait_cnt_ff == 32'h0;
   endproperty
   a_wait_exit: assert property (p_wait_exit) else $error("wait too short");

   property p_eight_chars;
      @(posedge ref_clk) disable iff (srst)
      (state_ff == apso_pkg::ST_SERIAL && nxt_state != apso_pkg::ST_SERIAL)
      |-> char_idx_ff == 3'h7 && bit_idx_ff == 4'h9;
   endproperty
   a_eight_chars: assert property (p_eight_chars) else $error("short message");

   property p_return;
      @(posedge ref_clk) disable iff (srst)
      (state_ff == apso_pkg::ST_HOLD && nxt_state == apso_pkg::ST_NORMAL)
      |-> hold_cnt_ff == 32'h0;
   endproperty
   a_return: assert property (p_return) else $error("early return");

   property p_burst_b;
      @(posedge ref_clk) disable iff (srst)
      state_ff == apso_pkg::ST_PULSES |=> quad_b_out == ($past(burst_b) ^
                                                        $past(ctrl_ff.dir));
   endproperty
   a_burst_b: assert property (p_burst_b) else $error("phase b wrong");

   property p_index;
      @(posedge ref_clk) disable iff (srst)
      1'b1 |=> index_pulse_out == $past(index_in);
   endproperty
   a_index: assert property (p_index) else $error("origin not passed");

   property p_normal_a;
      @(posedge ref_clk) disable iff (srst)
      state_ff == apso_pkg::ST_NORMAL |=> quad_a_out == $past(inc_a);
   endproperty
   a_normal_a: assert property (p_normal_a) else $error("phase a wrong");

   property p_pulse_step;
      @(posedge ref_clk) disable iff (srst)
      (state_ff == apso_pkg::ST_PULSES && phase_ff == 2'h3 &&
       quarter_cnt_ff == 8'h0 && nxt_state == apso_pkg::ST_PULSES)
      |=> pulse_left_ff == $past(pulse_left_ff) - 21'h1;
   endproperty
   a_pulse_step: assert property (p_pulse_step) else $error("bad count");

endmodule // apso_top
`default_nettype wire

// >>> design/apso_pkg.sv
// package for the absolute position serial output block
// assumes a 100 MHz ref_clk and a 32-bit AXI4-Lite register bus
package apso_pkg;

   // register byte offsets
   localparam logic [3:0] REG_CTRL_OFS = 4'h0;
   localparam logic [3:0] REG_STATUS_OFS = 4'h4;
   localparam logic [3:0] REG_REVS_OFS = 4'h8;
   localparam logic [3:0] REG_REMAIN_OFS = 4'hC;

   // control field positions and reset values
   localparam int CTRL_RES_LSB = 0;
   localparam int CTRL_DIR_BIT = 16;
   localparam logic [12:0] RES_RESET = 13'h0014;
   localparam logic [12:0] RES_MIN = 13'h0001;
   localparam logic [12:0] RES_MAX = 13'h1000;
   localparam logic DIR_RESET = 1'b0;

   // timing
   localparam longint CLK_HZ = 100000000;
   localparam longint SENSOR_DELAY_MS = 100;
   localparam longint RETURN_DELAY_MS = 400;
   localparam longint BAUD_BPS = 9600;
   localparam longint PULSE_PERIOD_PS = 1480000;
   localparam int SENSOR_DELAY_CYC = int'((SENSOR_DELAY_MS * CLK_HZ) / 1000);
   localparam int RETURN_DELAY_CYC = int'((RETURN_DELAY_MS * CLK_HZ) / 1000);
   localparam int BIT_CYC = int'(CLK_HZ / BAUD_BPS);
   localparam int QUARTER_CYC =
      int'((PULSE_PERIOD_PS * (CLK_HZ / 1000000)) / 4000000);

   // message layout
   localparam int FRAME_BITS = 10;
   localparam int MSG_CHARS = 8;
   localparam int DIGITS = 5;
   localparam int DIV_STEPS = 36;
   localparam logic [6:0] CHAR_LEAD = 7'h50;
   localparam logic [6:0] CHAR_PLUS = 7'h2B;
   localparam logic [6:0] CHAR_MINUS = 7'h2D;
   localparam logic [6:0] CHAR_ZERO = 7'h30;
   localparam logic [6:0] CHAR_CR = 7'h0D;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {ST_NORMAL, ST_WAIT, ST_SERIAL, ST_PULSES, ST_HOLD}
      apso_state_type;

   typedef struct packed {
      logic dir;
      logic [12:0] res;
   } apso_ctrl_type;

   typedef struct packed {
      logic a;
      logic b;
      logic c;
   } apso_quad_type;

endpackage

// >>> tb/apso_host_model.sv
// host side: sensor-on driver, serial receiver, pulse counter
// assumes phase A idles high before the first start bit
`timescale 1ns/100ps
`default_nettype none
module apso_host_model
#(
   parameter int BAUD = 8
)
(
   input wire logic ref_clk,
   input wire logic go,
   input wire logic quad_a_out,
   input wire logic quad_b_out,
   output logic sensor_on_pin,
   output logic [55:0] msg,
   output int nch,
   output int ferr,
   output int pulses,
   output logic b_seen,
   output logic signed [35:0] hpos
);
   logic [9:0] f;
   logic pa;
   int d;
   always @(posedge ref_clk) sensor_on_pin <= go;
   always
   begin
      @(posedge go);
      nch = 0;
      ferr = 0;
      pulses = 0;
      while (nch < 8)
      begin
         @(posedge ref_clk iff quad_a_out);
         @(posedge ref_clk iff !quad_a_out);
         if (nch == 0) b_seen = quad_b_out;
         repeat (BAUD / 2) @(posedge ref_clk);
         for (int i = 0; i < 10; i++)
         begin
            if (i > 0) repeat (BAUD) @(posedge ref_clk);
            f[i] = quad_a_out;
         end
         if (f[0] || !f[9] || ^f[8:1]) ferr++;
         msg = {msg[48:0], f[7:1]};
         nch++;
      end
      pa = 1'b1;
      while (go)
      begin
         // origin pulses never clear the count
         @(posedge ref_clk);
         if (quad_a_out && !pa) pulses++;
         pa = quad_a_out;
      end
      d = 0;
      for (int i = 4; i >= 0; i--) d = d * 10 + int'(msg[7*i+7 +: 7]) - 48;
      if (msg[48:42] == 7'h2D) d = -d;
      hpos = 36'(longint'(d) * 1048576 + pulses);
   end
endmodule // apso_host_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for apso_top against a host-side model
// assumes shortened wait, return and bit counts set below
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int RET = 2000;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic go = 1'b0;
   logic sensor_on_pin, quad_a_out, quad_b_out, index_pulse_out, b_seen;
   logic signed [35:0] abs_position = '0;
   logic signed [35:0] hpos;
   logic inc_a = 1'b0, inc_b = 1'b0, index_in = 1'b0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [55:0] msg;
   int nch, ferr, pulses, failures = 0, checked = 0, seed = 32'hF5D6;
   longint cyc = 0, t_hi = 0, t_sf = 0, t_end = 0;
   apso_top #(.SENSOR_CYC(50), .RETURN_CYC(RET), .BAUD_CYC(8)) u_apso_top (.*);
   apso_host_model #(.BAUD(8)) u_apso_host_model (.*);
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (go && quad_a_out && t_hi == 0) t_hi <= cyc;
      if (t_hi != 0 && !quad_a_out && t_sf == 0) t_sf <= cyc;
      if (t_sf != 0 && nch == 8 && t_end == 0) t_end <= cyc;
   end
   task automatic chk(input logic [63:0] seen, exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ta, tw, ad, wd;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      do
      begin
         @(negedge ref_clk);
         ta = s_axi_awready && !ad;
         tw = s_axi_wready && !wd;
         @(posedge ref_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         ad = ad | ta;
         wd = wd | tw;
      end while (!(ad && wd));
      @(negedge ref_clk iff s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge ref_clk iff s_axi_arready);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      @(negedge ref_clk iff s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic run_seq(input int res, input logic dir, input int revs,
                          input int rem);
      longint v, p;
      int fr, q;
      logic [1:0] r;
      logic [31:0] d;
      logic [55:0] e;
      logic [2:0] x, px;
      v = longint'(revs) * 1048576 + rem;
      fr = (res > 1) ? int'($unsigned($random(seed)) % res) : 0;
      p = v * res + ((v < 0) ? -fr : fr);
      wr(4'h0, {15'h0, dir, 3'h0, 13'(res)}, r);
      chk(r, apso_pkg::RESP_OKAY, "ctrl write");
      t_hi = 0;
      t_sf = 0;
      t_end = 0;
      abs_position <= p[35:0];
      go <= 1'b1;
      do rd(4'h4, d, r); while (d[4:1] == 4'h0);
      do rd(4'h4, d, r); while (d[4:1] != 4'h0);
      chk(cyc - t_end >= RET - 8 && cyc - t_end <= RET + 40, 1, "return");
      chk(t_sf - t_hi >= 50 && t_sf - t_hi <= 260, 1, "wait");
      rd(4'h8, d, r);
      chk(d, {{16{v[35]}}, v[35:20]}, "revs reg");
      rd(4'hC, d, r);
      chk(d, {12'h0, v[19:0]}, "remain reg");
      go <= 1'b0;
      repeat (3) @(posedge ref_clk);
      q = int'($signed(v[35:20]));
      e = {7'h50, (q < 0) ? 7'h2D : 7'h2B, 35'h0, 7'h0D};
      for (int k = 0; k < 5; k++)
         e[7*k+7 +: 7] = 7'h30 + 7'(((q < 0) ? -q : q) / 10**k % 10);
      chk(msg, e, "message");
      chk(nch, 8, "char count");
      chk(ferr, 0, "framing");
      chk(pulses, v[19:0], "burst");
      chk($unsigned(hpos), v[35:0], "position");
      chk(b_seen, dir, "b level");
      for (int i = 0; i < 12; i++)
      begin
         @(posedge ref_clk);
         x = 3'($random(seed));
         {inc_a, inc_b, index_in} <= x;
         @(negedge ref_clk);
         if (i > 0) chk({quad_a_out, quad_b_out, index_pulse_out}, px, "pass");
         px = x;
      end
      @(posedge ref_clk);
      {inc_a, inc_b, index_in} <= 3'h0;
      $display("sequence res %0d revs %0d done", res, revs);
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      wrap_up;
   end
   initial
   begin
      logic [1:0] r;
      logic [31:0] d;
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      wr(4'h0, 32'h0, r);
      rd(4'h0, d, r);
      chk(d, 32'h14, "ctrl reset");
      wr(4'h4, 32'h1, r);
      chk(r, apso_pkg::RESP_SLVERR, "ro write");
      rd(4'h2, d, r);
      chk({r, d}, {apso_pkg::RESP_SLVERR, 32'h0}, "unmapped");
      $display("register test done");
      run_seq(20, 1'b0, $random(seed) % 200, $random(seed) & 7);
      run_seq(1, 1'b1, 32767, 5);
      run_seq(1, 1'b0, -32768, 0);
      run_seq(4096, 1'b1, -3, 7);
      run_seq(7, 1'b0, 0, 2);
      wrap_up;
   end
endmodule // tb
`default_nettype wire
